// *** nfc_consts.svh ***
// Constants for the NAND host sequencer: command codes, widths, timing.
// Assumes an 8-bit NAND device and a 125 MHz host clock.
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define NFC_C_READ 8'h00
`define NFC_C_ERASE 8'h60
`define NFC_C_START 8'hD0
`define NFC_C_CBRD 8'h35
`define NFC_C_CBIN 8'h85
`define NFC_C_PROG 8'h10
`define NFC_C_STAT 8'h70
`define NFC_C_STAT2 8'h71
`define NFC_C_ID 8'h90
`define NFC_C_RESET 8'hFF
// ----------------------------------------
// Address layout: page in bits 5..0, block in bits 17..6
// ----------------------------------------
`define NFC_ROW_W 18
`define NFC_DIST_BIT 6
`define NFC_HALF_BIT 17
`define NFC_ID_LEN 13'h0005
// ----------------------------------------
// Timing: times in ns, cycle counts derived from the clock period
// ----------------------------------------
`define NFC_CLK_NS 8
`define NFC_WLO_NS 25
`define NFC_WHI_NS 15
`define NFC_REA_NS 20
`define NFC_WB_NS 100
`define NFC_SYNC_CYC 2
`define NFC_WLO_CYC ((`NFC_WLO_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_WHI_CYC ((`NFC_WHI_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RLO_CYC ((`NFC_REA_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS + `NFC_SYNC_CYC)
`define NFC_WB_CYC ((`NFC_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// *** nfc_pkg.sv ***
// Types shared by the NAND host sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package nfc_pkg;
  // User operations.
  typedef enum logic [2:0] {
    OP_ERASE = 3'h0, OP_ERASE2 = 3'h1, OP_CBREAD = 3'h2, OP_CBPROG = 3'h3,
    OP_ID = 3'h4, OP_STAT = 3'h5, OP_STAT2 = 3'h6, OP_RESET = 3'h7
  } nfc_op_t;
  // Kind of one script step.
  typedef enum logic [2:0] {
    K_CMD = 3'h0, K_ADR = 3'h1, K_WR = 3'h2, K_RD = 3'h3, K_WAIT = 3'h4, K_END = 3'h5
  } nfc_kind_t;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_STEP = 5'h02, S_LO = 5'h04, S_HI = 5'h08, S_BUSY = 5'h10
  } nfc_state_t;
endpackage : nfc_pkg

// *** nfc_host.sv ***
// NAND host sequencer: turns user operations into strobed pin cycles.
// Assumes an 8-bit NAND device on the pins and a pull-up on ready/busy.
`timescale 1ns/1ns
`default_nettype none
`include "nfc_consts.svh"

module nfc_host
  import nfc_pkg::*;
(
  input wire logic mclk_i, // System clock.
  input wire logic resetn_i, // Asynchronous reset, active low.
  input wire logic cmd_valid_i, // Operation request.
  output logic cmd_ready_o, // Sequencer idle and taking requests.
  input wire logic [2:0] cmd_op_i, // Operation code.
  input wire logic [15:0] cmd_col_i, // Column address.
  input wire logic [17:0] cmd_row_i, // Row address (block and page).
  input wire logic [17:0] cmd_row2_i, // Second row for dual erase.
  input wire logic [12:0] cmd_len_i, // Data bytes to write, or status bytes to read.
  input wire logic protect_i, // Hold the device write protected.
  output logic done_o, // Operation finished, one cycle.
  output logic err_o, // Request refused, one cycle.
  input wire logic wr_valid_i, // Write byte available.
  output logic wr_ready_o, // Write byte taken.
  input wire logic [7:0] wr_data_i, // Write byte.
  output logic rd_valid_o, // Read byte available.
  input wire logic rd_ready_i, // Read byte taken.
  output logic [7:0] rd_data_o, // Read byte.
  output logic chip_en_n_o, // Chip enable, active low.
  output logic cmd_latch_o, // Command latch enable.
  output logic addr_latch_o, // Address latch enable.
  output logic write_strobe_n_o, // Write strobe, active low.
  output logic read_strobe_n_o, // Read strobe, active low.
  output logic write_prot_n_o, // Write protect, active low.
  output logic [7:0] io_line_o, // Data bus out.
  output logic io_line_oe_o, // Data bus driven by this block.
  input wire logic [7:0] io_line_i, // Data bus in.
  input wire logic ready_busy_out_i // Device ready (high) or busy (low).
);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_s1_r, rst_n; // Reset release pair.
  logic [7:0] io_s1_r, io_s2_r; // Data bus synchroniser.
  logic rb_s1_r, rb_s2_r; // Ready/busy synchroniser.

  // Reset asserts at once but leaves on the clock, so no flop sees a half edge.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Pins come from another domain; only the second stage is read.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      io_s1_r <= io_line_i;
      io_s2_r <= io_s1_r;
      rb_s1_r <= ready_busy_out_i;
      rb_s2_r <= rb_s1_r;
    end
  end

  // ----------------------------------------
  // Scripts and decoders
  // ----------------------------------------
  // Step of an operation: kind in bits 10..8, code or address index below.
  function automatic logic [10:0] step(input nfc_op_t op, input logic [3:0] ph);
    logic [10:0] s;
    s = {K_END, 8'h00};
    case (op)
      OP_ERASE: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_ERASE};
          4'h1: s = {K_ADR, 8'h02};
          4'h2: s = {K_ADR, 8'h03};
          4'h3: s = {K_ADR, 8'h04};
          4'h4: s = {K_CMD, `NFC_C_START};
          4'h5: s = {K_WAIT, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      OP_ERASE2: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_ERASE};
          4'h1: s = {K_ADR, 8'h02};
          4'h2: s = {K_ADR, 8'h03};
          4'h3: s = {K_ADR, 8'h04};
          4'h4: s = {K_CMD, `NFC_C_ERASE};
          4'h5: s = {K_ADR, 8'h05};
          4'h6: s = {K_ADR, 8'h06};
          4'h7: s = {K_ADR, 8'h07};
          4'h8: s = {K_CMD, `NFC_C_START};
          4'h9: s = {K_WAIT, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      OP_CBREAD: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_READ};
          4'h1: s = {K_ADR, 8'h00};
          4'h2: s = {K_ADR, 8'h01};
          4'h3: s = {K_ADR, 8'h02};
          4'h4: s = {K_ADR, 8'h03};
          4'h5: s = {K_ADR, 8'h04};
          4'h6: s = {K_CMD, `NFC_C_CBRD};
          4'h7: s = {K_WAIT, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      OP_CBPROG: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_CBIN};
          4'h1: s = {K_ADR, 8'h00};
          4'h2: s = {K_ADR, 8'h01};
          4'h3: s = {K_ADR, 8'h02};
          4'h4: s = {K_ADR, 8'h03};
          4'h5: s = {K_ADR, 8'h04};
          4'h6: s = {K_WR, 8'h00};
          4'h7: s = {K_CMD, `NFC_C_PROG};
          4'h8: s = {K_WAIT, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      OP_ID: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_ID};
          4'h1: s = {K_ADR, 8'hFF};
          4'h2: s = {K_RD, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      OP_STAT, OP_STAT2: begin
        case (ph)
          4'h0: s = {K_CMD, (op == OP_STAT) ? `NFC_C_STAT : `NFC_C_STAT2};
          4'h1: s = {K_RD, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      default: begin
        case (ph)
          4'h0: s = {K_CMD, `NFC_C_RESET};
          4'h1: s = {K_WAIT, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
    endcase
    return s;
  endfunction : step

  // True for operations that may go out while the device is busy.
  function automatic logic busy_ok(input nfc_op_t op);
    return (op == OP_STAT) || (op == OP_STAT2) || (op == OP_RESET);
  endfunction : busy_ok

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  nfc_state_t st_r, st_nxt; // Sequencer state.
  nfc_op_t op_r, op_nxt; // Operation in flight.
  logic [3:0] ph_r, ph_nxt; // Step index.
  logic [3:0] cnt_r, cnt_nxt; // Strobe or wait timer.
  logic [12:0] len_r, len_nxt; // Data bytes left.
  logic [15:0] col_r, col_nxt; // Column address.
  logic [17:0] row_r, row_nxt, row2_r, row2_nxt; // Row addresses.
  logic cb_ok_r, cb_ok_nxt, cb_dist_r, cb_dist_nxt; // Copy-back source district.
  logic cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt, re_r, re_nxt; // Pin levels.
  logic oe_r, oe_nxt, wp_r, wp_nxt, done_r, done_nxt, err_r, err_nxt; // Pin and pulses.
  logic [7:0] io_r, io_nxt, abyte; // Bus value and address byte.
  logic [10:0] cur; // Current step.
  nfc_kind_t kind; // Kind of current step.
  logic push, refuse; // Buffer write; request refusal.
  logic [1:0] bcnt_r, bcnt_nxt; // Buffer fill.
  logic [7:0] b0_r, b0_nxt, b1_r, b1_nxt; // Buffer entries, b0 is the head.

  assign cur = step(op_r, ph_r);
  assign kind = nfc_kind_t'(cur[10:8]);
  assign cmd_ready_o = (st_r == S_IDLE);
  assign wr_ready_o = (st_r == S_STEP) && (kind == K_WR) && (len_r != 13'h0000);

  // Address cycles go out low byte first: column, then row.
  always_comb begin
    case (cur[2:0])
      3'h0: abyte = col_r[7:0];
      3'h1: abyte = col_r[15:8];
      3'h2: abyte = row_r[7:0];
      3'h3: abyte = row_r[15:8];
      3'h4: abyte = {6'h00, row_r[17:16]};
      3'h5: abyte = row2_r[7:0];
      3'h6: abyte = row2_r[15:8];
      default: abyte = (cur[7:0] == 8'h07) ? {6'h00, row2_r[17:16]} : 8'h00;
    endcase
  end

  // Busy and pairing checks on the requested operation; block order is never checked.
  always_comb begin
    refuse = 1'b0;
    if (!rb_s2_r && !busy_ok(nfc_op_t'(cmd_op_i)))
      refuse = 1'b1;
    else if (nfc_op_t'(cmd_op_i) == OP_ERASE2)
      refuse = (cmd_row_i[`NFC_HALF_BIT] != cmd_row2_i[`NFC_HALF_BIT])
        || (cmd_row_i[`NFC_DIST_BIT] == cmd_row2_i[`NFC_DIST_BIT]);
    else if (nfc_op_t'(cmd_op_i) == OP_CBPROG)
      refuse = !cb_ok_r || (cb_dist_r != cmd_row_i[`NFC_DIST_BIT]);
  end

  // Next values of the sequencer and its pins.
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    col_nxt = col_r;
    row_nxt = row_r;
    row2_nxt = row2_r;
    cb_ok_nxt = cb_ok_r;
    cb_dist_nxt = cb_dist_r;
    cle_nxt = cle_r;
    ale_nxt = ale_r;
    we_nxt = we_r;
    re_nxt = re_r;
    oe_nxt = oe_r;
    io_nxt = io_r;
    wp_nxt = !protect_i;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    push = 1'b0;
    case (st_r)
      S_IDLE: begin
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (cmd_valid_i && refuse) begin
          err_nxt = 1'b1;
        end else if (cmd_valid_i) begin
          op_nxt = nfc_op_t'(cmd_op_i);
          ph_nxt = 4'h0;
          col_nxt = cmd_col_i;
          row_nxt = cmd_row_i;
          row2_nxt = cmd_row2_i;
          len_nxt = (nfc_op_t'(cmd_op_i) == OP_ID) ? `NFC_ID_LEN : cmd_len_i;
          if (nfc_op_t'(cmd_op_i) == OP_CBREAD) begin
            cb_ok_nxt = 1'b1;
            cb_dist_nxt = cmd_row_i[`NFC_DIST_BIT];
          end
          st_nxt = S_STEP;
        end
      end
      S_STEP: begin
        cle_nxt = (kind == K_CMD);
        ale_nxt = (kind == K_ADR);
        oe_nxt = (kind == K_CMD) || (kind == K_ADR) || (kind == K_WR);
        case (kind)
          K_CMD, K_ADR: begin
            io_nxt = (kind == K_CMD) ? cur[7:0] : abyte;
            we_nxt = 1'b0;
            cnt_nxt = 4'(`NFC_WLO_CYC);
            st_nxt = S_LO;
          end
          K_WR: begin
            if (len_r == 13'h0000) begin
              ph_nxt = ph_r + 4'h1;
            end else if (wr_valid_i) begin
              io_nxt = wr_data_i;
              we_nxt = 1'b0;
              cnt_nxt = 4'(`NFC_WLO_CYC);
              st_nxt = S_LO;
            end
          end
          K_RD: begin
            // A full buffer holds off the next strobe so no byte is lost.
            if (len_r == 13'h0000) begin
              ph_nxt = ph_r + 4'h1;
            end else if (bcnt_r != 2'h2) begin
              re_nxt = 1'b0;
              cnt_nxt = 4'(`NFC_RLO_CYC);
              st_nxt = S_LO;
            end
          end
          K_WAIT: begin
            cnt_nxt = 4'(`NFC_WB_CYC);
            st_nxt = S_BUSY;
          end
          default: begin
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
        endcase
      end
      S_LO: begin
        if (cnt_r == 4'h1) begin
          we_nxt = 1'b1;
          re_nxt = 1'b1;
          push = (kind == K_RD);
          cnt_nxt = 4'(`NFC_WHI_CYC);
          st_nxt = S_HI;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_HI: begin
        // Bus and latch levels stay through the high time to meet hold.
        if (cnt_r == 4'h1) begin
          st_nxt = S_STEP;
          if ((kind == K_WR) || (kind == K_RD)) begin
            len_nxt = len_r - 13'h0001;
            if (len_r == 13'h0001)
              ph_nxt = ph_r + 4'h1;
          end else begin
            ph_nxt = ph_r + 4'h1;
          end
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_BUSY: begin
        // The device may take a while to pull busy; wait before sampling it.
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (rb_s2_r) begin
          ph_nxt = ph_r + 4'h1;
          st_nxt = S_STEP;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      op_r <= OP_RESET;
      ph_r <= 4'h0;
      cnt_r <= 4'h0;
      len_r <= 13'h0000;
      col_r <= 16'h0000;
      row_r <= 18'h00000;
      row2_r <= 18'h00000;
      cb_ok_r <= 1'b0;
      cb_dist_r <= 1'b0;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_r <= 1'b1;
      re_r <= 1'b1;
      oe_r <= 1'b0;
      io_r <= 8'h00;
      wp_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      row2_r <= row2_nxt;
      cb_ok_r <= cb_ok_nxt;
      cb_dist_r <= cb_dist_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_r <= we_nxt;
      re_r <= re_nxt;
      oe_r <= oe_nxt;
      io_r <= io_nxt;
      wp_r <= wp_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------
  // Two-entry read buffer
  // ----------------------------------------
  // Next buffer contents from push and pop.
  always_comb begin
    bcnt_nxt = bcnt_r;
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    case ({push, rd_valid_o && rd_ready_i})
      2'b10: begin
        if (bcnt_r == 2'h0) b0_nxt = io_s2_r;
        else b1_nxt = io_s2_r;
        bcnt_nxt = bcnt_r + 2'h1;
      end
      2'b01: begin
        b0_nxt = b1_r;
        bcnt_nxt = bcnt_r - 2'h1;
      end
      2'b11: begin
        if (bcnt_r == 2'h1) begin
          b0_nxt = io_s2_r;
        end else begin
          b0_nxt = b1_r;
          b1_nxt = io_s2_r;
        end
      end
      default: bcnt_nxt = bcnt_r;
    endcase
  end

  // Buffer registers.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= 2'h0;
      b0_r <= 8'h00;
      b1_r <= 8'h00;
    end else begin
      bcnt_r <= bcnt_nxt;
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
    end
  end

  assign rd_valid_o = (bcnt_r != 2'h0);
  assign rd_data_o = b0_r;
  assign done_o = done_r;
  assign err_o = err_r;
  assign chip_en_n_o = (st_r == S_IDLE);
  assign cmd_latch_o = cle_r;
  assign addr_latch_o = ale_r;
  assign write_strobe_n_o = we_r;
  assign read_strobe_n_o = re_r;
  assign write_prot_n_o = wp_r;
  assign io_line_o = io_r;
  assign io_line_oe_o = oe_r;

endmodule : nfc_host
`default_nettype wire

// *** nfc_chk_monitor.sv ***
// Pin checker for the NAND host sequencer.
// Bound into nfc_host by the bench; it sees that module's ports only.
`timescale 1ns/1ns
`default_nettype none
`include "nfc_consts.svh"
module nfc_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [2:0] cmd_op_i,
  input wire logic [17:0] cmd_row_i,
  input wire logic [17:0] cmd_row2_i,
  input wire logic err_o,
  input wire logic chip_en_n_o,
  input wire logic cmd_latch_o,
  input wire logic write_strobe_n_o,
  input wire logic [7:0] io_line_o,
  input wire logic io_line_oe_o,
  input wire logic ready_busy_out_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Last command the device latched, so a code can be judged by what preceded it.
  logic [7:0] last_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_r <= 8'h00;
    end else if ($rose(write_strobe_n_o) && cmd_latch_o) begin
      last_r <= io_line_o;
    end
  end
  // A command byte latched on the rising write strobe.
  sequence s_cmd(logic [7:0] c);
    $rose(write_strobe_n_o) && cmd_latch_o && io_line_o == c;
  endsequence
  // A user request taken by the sequencer.
  sequence s_take(logic [2:0] op);
    cmd_valid_i && cmd_ready_o && cmd_op_i == op;
  endsequence
  property p_start; s_cmd(`NFC_C_START) |-> last_r == `NFC_C_ERASE; endproperty
  a_start: assert property (p_start) else $error("start code without setup");
  property p_confirm; s_cmd(`NFC_C_PROG) |-> last_r == `NFC_C_CBIN; endproperty
  a_confirm: assert property (p_confirm) else $error("confirm without input");
  property p_busy;
    $rose(write_strobe_n_o) && cmd_latch_o && !ready_busy_out_i && !$past(ready_busy_out_i, 4)
      |-> io_line_o inside {`NFC_C_STAT, `NFC_C_STAT2, `NFC_C_RESET};
  endproperty
  a_busy: assert property (p_busy) else $error("command sent while busy");
  property p_half; s_take(3'h1) ##0 (cmd_row_i[17] != cmd_row2_i[17]) |=> err_o; endproperty
  a_half: assert property (p_half) else $error("cross-half pair taken");
  property p_dist; s_take(3'h1) ##0 (cmd_row_i[6] == cmd_row2_i[6]) |=> err_o; endproperty
  a_dist: assert property (p_dist) else $error("same-district pair taken");
  property p_wlow;
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*4] ##1 write_strobe_n_o;
  endproperty
  a_wlow: assert property (p_wlow) else $error("write strobe width wrong");
  property p_held;
    $rose(write_strobe_n_o) && cmd_latch_o |-> io_line_oe_o && $stable(io_line_o);
  endproperty
  a_held: assert property (p_held) else $error("command byte not held");
  property p_select; !write_strobe_n_o |-> !chip_en_n_o; endproperty
  a_select: assert property (p_select) else $error("strobe without chip enable");
endmodule : nfc_chk
`default_nettype wire

// *** nfc_dev_model.sv ***
// Behavioural NAND device facing the host sequencer pins.
// Assumes the bench joins the data bus here; ready/busy is pulled up.
`timescale 1ns/1ns
`default_nettype none
module nfc_dev_model #(
  parameter int BUSY_NS = 400,
  parameter logic [7:0] MAKER = 8'h00, // Arbitrary value.
  parameter logic [7:0] DEVICE = 8'h00, // Arbitrary value.
  parameter logic [7:0] CODES = 8'h00, // Cells, chips, block, page codes.
  parameter logic [2:0] DX = 3'h2 // District code and ECC flag.
) (
  input wire logic chip_en_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] host_io_i,
  input wire logic host_oe_i,
  input wire logic hold_busy_i,
  input wire logic [1:0] fail_mask_i,
  output logic [7:0] io_o,
  output logic rb_o
);
  logic [9:0] log_q[$]; // Every latched byte, tagged command, address or data.
  logic [7:0] mode_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [7:0] dat;
  logic [1:0] seen_r = 2'h0;
  logic [1:0] dfail_r = 2'h0;
  logic busy_r = 1'b0;
  logic rdy;
  logic m71;
  int aidx = 0;
  int idx = 0;
  event go;
  assign rdy = !(busy_r || hold_busy_i);
  assign rb_o = rdy;
  assign m71 = (mode_r == 8'h71);
  // ID bytes in order, else the status byte, repeated on every read.
  always_comb begin
    case (idx)
      0: dat = MAKER;
      1: dat = DEVICE;
      2: dat = {4'h9, CODES[7:4]};
      3: dat = {2'h0, CODES[3:2], 2'h1, CODES[1:0]};
      default: dat = {DX[0], 3'h7, DX[2:1], 2'h2};
    endcase
    if (mode_r != 8'h90) begin
      dat = {wp_n_i, rdy, rdy, 2'h0,
             m71 & dfail_r[1], m71 & dfail_r[0], |dfail_r};
    end
  end
  // Released bus shows the inverse of the last byte, never a stale copy.
  assign io_o = host_oe_i ? host_io_i : (!re_n_i && !chip_en_n_i) ? dat : ~last_r;
  always @(posedge re_n_i) if (!chip_en_n_i) begin
    last_r = dat;
    if (idx < 4) idx++;
  end
  // Busy for a fixed span after each start, confirm or reset code.
  always @(go) begin
    busy_r = 1'b1;
    #(BUSY_NS);
    busy_r = 1'b0;
  end
  always @(posedge we_n_i) if (!chip_en_n_i) begin
    if (cle_i) begin
      log_q.push_back({2'h2, host_io_i});
      mode_r = host_io_i;
      aidx = 0;
      idx = 0;
      if (host_io_i == 8'hD0) begin
        dfail_r = fail_mask_i & seen_r;
        seen_r = 2'h0;
      end
      if (host_io_i inside {8'hD0, 8'h35, 8'h10, 8'hFF}) -> go;
    end else if (ale_i) begin
      log_q.push_back({2'h1, host_io_i});
      if (mode_r == 8'h60 && aidx == 0) seen_r[host_io_i[6]] = 1'b1;
      aidx++;
    end else begin
      log_q.push_back({2'h0, host_io_i});
    end
  end
endmodule : nfc_dev_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the NAND host sequencer.
// Assumes nfc_host, nfc_chk and nfc_dev_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import nfc_pkg::*;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DV = 8'hA5; // Arbitrary value.
  logic mclk_i = 1'b0, resetn_i = 1'b0, cmd_valid_i = 1'b0, protect_i = 1'b0;
  logic [2:0] cmd_op_i = 3'h0;
  logic [15:0] cmd_col_i = 16'h0000;
  logic [17:0] cmd_row_i = 18'h00000, cmd_row2_i = 18'h00000;
  logic [12:0] cmd_len_i = 13'h0000;
  logic wr_valid_i = 1'b0, rd_ready_i = 1'b0, hold_busy = 1'b0;
  logic [7:0] wr_data_i = 8'h00, io_line_i, io_line_o, rd_data_o;
  logic [1:0] fail_mask = 2'h0;
  logic cmd_ready_o, done_o, err_o, wr_ready_o, rd_valid_o, chip_en_n_o, cmd_latch_o;
  logic addr_latch_o, write_strobe_n_o, read_strobe_n_o, write_prot_n_o, io_line_oe_o;
  logic ready_busy_out_i;
  int mismatches = 0, tests_run = 0, stall = 0;
  logic [7:0] rq[$], wq[$];
  nfc_host dut (.*);
  nfc_dev_model #(.MAKER(MK), .DEVICE(DV), .CODES(8'h05), .DX(3'h2)) u_dev (
    .chip_en_n_i(chip_en_n_o), .cle_i(cmd_latch_o), .ale_i(addr_latch_o),
    .we_n_i(write_strobe_n_o), .re_n_i(read_strobe_n_o), .wp_n_i(write_prot_n_o),
    .host_io_i(io_line_o), .host_oe_i(io_line_oe_o), .hold_busy_i(hold_busy),
    .fail_mask_i(fail_mask), .io_o(io_line_i), .rb_o(ready_busy_out_i));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic cv(input string nm, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cv
  task automatic cf(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : cf
  task automatic chk_log(input logic [9:0] e[$]);
    cv("log length", 10'(e.size()), 10'(u_dev.log_q.size()));
    foreach (e[i]) cv("pin byte", e[i], u_dev.log_q[i]);
  endtask : chk_log
  // Issues one request, feeds and drains the streams, judges the outcome.
  task automatic run_op(input logic [2:0] op, input logic [17:0] r1, input logic [17:0] r2,
                        input logic [15:0] col, input logic [12:0] len, input logic eerr);
    int n;
    int wi;
    logic tw;
    logic tr;
    logic [7:0] b;
    logic fin;
    logic rf;
    n = 0;
    wi = 0;
    fin = 1'b0;
    rq.delete();
    u_dev.log_q.delete();
    cmd_op_i = op;
    cmd_row_i = r1;
    cmd_row2_i = r2;
    cmd_col_i = col;
    cmd_len_i = len;
    wr_valid_i = (wq.size() > 0);
    if (wq.size() > 0) wr_data_i = wq[0];
    cmd_valid_i = 1'b1;
    while (!cmd_ready_o) tick();
    tick();
    cmd_valid_i = 1'b0;
    // A refusal pulses once, just after the take, so catch it here.
    rf = err_o;
    fin = err_o;
    while (!fin && n < 6000) begin
      tw = wr_valid_i && wr_ready_o;
      tr = rd_valid_o && rd_ready_i;
      b = rd_data_o;
      tick();
      n++;
      if (tr) rq.push_back(b);
      if (tw) wi++;
      wr_valid_i = (wi < wq.size());
      if (wi < wq.size()) wr_data_i = wq[wi];
      rd_ready_i = (stall == 0);
      if (stall > 0) stall--;
      fin = done_o || err_o;
      rf = rf | err_o;
    end
    cf("finished", 1'b1, fin);
    cf("refused", eerr, rf);
    repeat (4) begin
      if (rd_valid_o && rd_ready_i) rq.push_back(rd_data_o);
      tick();
    end
    wq.delete();
  endtask : run_op
  task automatic t_dual();
    fail_mask = 2'h2;
    run_op(3'h1, 18'h000C0, 18'h00100, 16'h0, 13'h0, 1'b0);
    chk_log('{10'h260, 10'h1C0, 10'h100, 10'h100, 10'h260, 10'h100, 10'h101, 10'h100,
              10'h2D0});
    run_op(3'h6, 18'h0, 18'h0, 16'h0, 13'h1, 1'b0);
    cv("district status", 10'h0E5, {2'h0, rq[0]});
    run_op(3'h5, 18'h0, 18'h0, 16'h0, 13'h1, 1'b0);
    cv("status", 10'h0E1, {2'h0, rq[0]});
    run_op(3'h1, 18'h000C0, 18'h20100, 16'h0, 13'h0, 1'b1);
    run_op(3'h1, 18'h000C0, 18'h00040, 16'h0, 13'h0, 1'b1);
    cv("idle pins", 10'h000, 10'(u_dev.log_q.size()));
  endtask : t_dual
  task automatic t_erase();
    fail_mask = 2'h0;
    run_op(3'h0, 18'h00140, 18'h0, 16'h0, 13'h0, 1'b0);
    chk_log('{10'h260, 10'h140, 10'h101, 10'h100, 10'h2D0});
    run_op(3'h5, 18'h0, 18'h0, 16'h0, 13'h1, 1'b0);
    cv("status", 10'h0E0, {2'h0, rq[0]});
  endtask : t_erase
  task automatic t_busy();
    hold_busy = 1'b1;
    repeat (4) tick();
    run_op(3'h0, 18'h00140, 18'h0, 16'h0, 13'h0, 1'b1);
    cv("idle pins", 10'h000, 10'(u_dev.log_q.size()));
    stall = 30;
    run_op(3'h5, 18'h0, 18'h0, 16'h0, 13'h3, 1'b0);
    cv("reads", 10'h003, 10'(rq.size()));
    foreach (rq[i]) cv("busy status", 10'h080, {2'h0, rq[i]});
    hold_busy = 1'b0;
    protect_i = 1'b1;
    repeat (4) tick();
    run_op(3'h5, 18'h0, 18'h0, 16'h0, 13'h1, 1'b0);
    cv("protect status", 10'h060, {2'h0, rq[0]});
    protect_i = 1'b0;
    repeat (4) tick();
  endtask : t_busy
  task automatic t_id();
    logic [7:0] e[5] = '{MK, DV, 8'h90, 8'h15, 8'h76};
    run_op(3'h4, 18'h0, 18'h0, 16'h0, 13'h0, 1'b0);
    chk_log('{10'h290, 10'h100});
    for (int i = 0; i < 5; i++) begin
      cv("id byte", {2'h0, e[i]}, {2'h0, rq[i]});
    end
  endtask : t_id
  task automatic t_copy();
    run_op(3'h2, 18'h00081, 18'h0, 16'h0, 13'h0, 1'b0);
    chk_log('{10'h200, 10'h100, 10'h100, 10'h181, 10'h100, 10'h100, 10'h235});
    wq = '{8'hAA, 8'h55};
    run_op(3'h3, 18'h00103, 18'h0, 16'h0010, 13'h2, 1'b0);
    chk_log('{10'h285, 10'h110, 10'h100, 10'h103, 10'h101, 10'h100, 10'h0AA, 10'h055,
              10'h210});
    run_op(3'h3, 18'h00040, 18'h0, 16'h0, 13'h0, 1'b1);
    run_op(3'h7, 18'h0, 18'h0, 16'h0, 13'h0, 1'b0);
    chk_log('{10'h2FF});
  endtask : t_copy
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (6) tick();
    t_dual();
    t_erase();
    t_busy();
    t_id();
    t_copy();
    end_of_test();
  end
  // Whole run needs well under 30000 cycles.
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule : tb
bind nfc_host nfc_chk u_chk (.*);
`default_nettype wire
